// *** hw/rxpsl_top.sv ***
// receiver parameter-set loader with wishbone register access
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "rxpsl_regs.svh"
module rxpsl_top #(
  parameter int         ADDR_W        = 11,
  parameter int         CNT_W         = 4,
  parameter int         SET_WORDS     = 4,
  parameter logic       WAKE_FLAG_RST = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              sleep_exit,
  output logic                   nvm_rd_req,
  output logic [ADDR_W-1:0]      nvm_rd_addr,
  input  wire logic              nvm_rd_ack,
  input  wire logic [31:0]       nvm_rd_data,
  output logic                   rx_param_valid,
  output logic [31:0]            rx_param_data,
  output logic [CNT_W-1:0]       rx_param_index,
  output logic [1:0]             rx_param_set,
  output logic                   rx_param_apply,
  output logic [31:0]            regulator_tune_register
);

  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    return adr[7:2] == idx;
  endfunction : hit

  // storage base address of each set
  // reserved code falls back to the default base; it is never fetched
  function automatic logic [ADDR_W-1:0] set_base(input logic [1:0] sel);
    logic [ADDR_W-1:0] b;
    b = ADDR_W'(`RXPSL_ADDR_SET_DFLT);
    if (sel == `RXPSL_SEL_SHORT) begin
      b = ADDR_W'(`RXPSL_ADDR_SET_SHORT);
    end else if (sel == `RXPSL_SEL_TIGHT) begin
      b = ADDR_W'(`RXPSL_ADDR_SET_TIGHT);
    end
    return b;
  endfunction : set_base

  // register state
  logic [1:0]  sel_q, sel_d;
  logic        set_trig_q, set_trig_d;
  logic        cal_trig_q, cal_trig_d;
  logic        wake_flag_q, wake_flag_d;
  logic [31:0] tune_q, tune_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  // sequencing state
  rxpsl_pkg::rxpsl_job_t job_q, job_d;
  rxpsl_pkg::rxpsl_set_t active_q, active_d;
  rxpsl_pkg::rxpsl_set_t loading_q, loading_d;
  logic        auto_pend_q, auto_pend_d;
  logic        apply_q, apply_d;

  // sleep-exit synchroniser
  logic        wake_s1_q;
  logic        wake_s2_q;
  logic        wake_prev_q;
  logic        wake_rise;

  // fetch engine hookup
  // one fetch at a time; a trigger waits while the engine is busy
  logic              f_start;
  logic [ADDR_W-1:0] f_addr;
  logic [CNT_W-1:0]  f_len;
  logic              f_busy;
  logic              f_done;
  logic              f_wv;
  logic [31:0]       f_wd;
  logic [CNT_W-1:0]  f_wi;

  logic        wb_req;
  logic        wr_sf;
  logic        sf_lane;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1_q   <= 1'b0;
      wake_s2_q   <= 1'b0;
      wake_prev_q <= 1'b0;
    end else begin
      wake_s1_q   <= sleep_exit;
      wake_s2_q   <= wake_s1_q;
      wake_prev_q <= wake_s2_q;
    end
  end

  // prev flop feeds only the edge detector, never the first stage
  assign wake_rise = wake_s2_q & ~wake_prev_q;

  // wishbone classic: one registered ack per request
  // write commits on the edge that raises ack; unused read bits are zero
  assign wb_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  assign sf_lane = wb_sel_i[0];
  assign wr_sf   = wb_req & wb_we_i & sf_lane & hit(wb_adr_i, `RXPSL_IDX_SF_CTRL);

  always_comb begin
    ack_d  = wb_req;
    rdat_d = rdat_q;
    if (wb_req && !wb_we_i) begin
      rdat_d = 32'h0000_0000;
      if (hit(wb_adr_i, `RXPSL_IDX_SF_CTRL)) begin
        rdat_d[`RXPSL_SF_SET_TRIG_BIT]           = set_trig_q;
        rdat_d[`RXPSL_SF_CAL_TRIG_BIT]           = cal_trig_q;
        rdat_d[`RXPSL_SF_SEL_MSB:`RXPSL_SF_SEL_LSB] = sel_q;
      end else if (hit(wb_adr_i, `RXPSL_IDX_WAKE_CFG)) begin
        rdat_d[`RXPSL_WCFG_L64_BIT] = wake_flag_q;
      end else if (hit(wb_adr_i, `RXPSL_IDX_TUNE)) begin
        rdat_d = tune_q;
      end else if (hit(wb_adr_i, `RXPSL_IDX_STATUS)) begin
        rdat_d[1:0] = active_q;
        rdat_d[2]   = f_busy;
        rdat_d[3]   = auto_pend_q;
      end
    end
  end

  // job arbitration: automatic load first, then tune, then set
  always_comb begin
    sel_d       = sel_q;
    set_trig_d  = set_trig_q;
    cal_trig_d  = cal_trig_q;
    wake_flag_d = wake_flag_q;
    tune_d      = tune_q;
    job_d       = job_q;
    active_d    = active_q;
    loading_d   = loading_q;
    auto_pend_d = auto_pend_q | wake_rise;
    apply_d     = 1'b0;
    f_start     = 1'b0;
    f_addr      = set_base(`RXPSL_SEL_DEFAULT);
    f_len       = CNT_W'(SET_WORDS);

    // tune word lands when the single fetch returns
    if (job_q == rxpsl_pkg::RXPSL_JOB_LDO && f_wv) begin
      tune_d = f_wd;
    end

    if (f_done) begin
      job_d = rxpsl_pkg::RXPSL_JOB_NONE;
      if (job_q == rxpsl_pkg::RXPSL_JOB_OPS) begin
        set_trig_d = 1'b0;
      end
      if (job_q == rxpsl_pkg::RXPSL_JOB_LDO) begin
        cal_trig_d = 1'b0;
      end
      if (job_q != rxpsl_pkg::RXPSL_JOB_LDO) begin
        active_d = loading_q;
        apply_d  = 1'b1;
      end
    end else if (job_q == rxpsl_pkg::RXPSL_JOB_NONE && !f_busy) begin
      if (auto_pend_q) begin
        auto_pend_d = wake_rise;
        if (wake_flag_q) begin
          f_start   = 1'b1;
          f_addr    = set_base(`RXPSL_SEL_SHORT);
          loading_d = rxpsl_pkg::RXPSL_SET_SHORT;
          job_d     = rxpsl_pkg::RXPSL_JOB_AUTO;
        end else begin
          active_d = rxpsl_pkg::RXPSL_SET_DEFAULT;
          apply_d  = 1'b1;
        end
      end else if (cal_trig_q) begin
        f_start = 1'b1;
        f_addr  = ADDR_W'(`RXPSL_ADDR_TUNE_CAL);
        f_len   = CNT_W'(1);
        job_d   = rxpsl_pkg::RXPSL_JOB_LDO;
      end else if (set_trig_q) begin
        if (sel_q == `RXPSL_SEL_RESERVED) begin
          set_trig_d = 1'b0;
        end else begin
          f_start   = 1'b1;
          f_addr    = set_base(sel_q);
          loading_d = rxpsl_pkg::rxpsl_set_t'(sel_q);
          job_d     = rxpsl_pkg::RXPSL_JOB_OPS;
        end
      end
    end

    // software writes; a set from software wins over completion clear
    if (wr_sf) begin
      sel_d = wb_dat_i[`RXPSL_SF_SEL_MSB:`RXPSL_SF_SEL_LSB];
      if (wb_dat_i[`RXPSL_SF_SET_TRIG_BIT]) begin
        set_trig_d = 1'b1;
      end
      if (wb_dat_i[`RXPSL_SF_CAL_TRIG_BIT]) begin
        cal_trig_d = 1'b1;
      end
    end
    if (wb_req && wb_we_i && sf_lane && hit(wb_adr_i, `RXPSL_IDX_WAKE_CFG)) begin
      wake_flag_d = wb_dat_i[`RXPSL_WCFG_L64_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q       <= `RXPSL_SEL_DEFAULT;
      set_trig_q  <= 1'b0;
      cal_trig_q  <= 1'b0;
      wake_flag_q <= WAKE_FLAG_RST;
      tune_q      <= `RXPSL_TUNE_RST;
      ack_q       <= 1'b0;
      rdat_q      <= 32'h0000_0000;
      job_q       <= rxpsl_pkg::RXPSL_JOB_NONE;
      active_q    <= rxpsl_pkg::RXPSL_SET_NONE;
      loading_q   <= rxpsl_pkg::RXPSL_SET_DEFAULT;
      // reset counts as a wake event
      auto_pend_q <= 1'b1;
      apply_q     <= 1'b0;
    end else begin
      sel_q       <= sel_d;
      set_trig_q  <= set_trig_d;
      cal_trig_q  <= cal_trig_d;
      wake_flag_q <= wake_flag_d;
      tune_q      <= tune_d;
      ack_q       <= ack_d;
      rdat_q      <= rdat_d;
      job_q       <= job_d;
      active_q    <= active_d;
      loading_q   <= loading_d;
      auto_pend_q <= auto_pend_d;
      apply_q     <= apply_d;
    end
  end

  rxpsl_fetch #(
    .ADDR_W (ADDR_W),
    .CNT_W  (CNT_W)
  ) u_fetch (
    .clk         (clk),
    .rst_n       (rst_n),
    .start       (f_start),
    .start_addr  (f_addr),
    .start_len   (f_len),
    .busy        (f_busy),
    .done        (f_done),
    .word_valid  (f_wv),
    .word_data   (f_wd),
    .word_index  (f_wi),
    .nvm_rd_req  (nvm_rd_req),
    .nvm_rd_addr (nvm_rd_addr),
    .nvm_rd_ack  (nvm_rd_ack),
    .nvm_rd_data (nvm_rd_data)
  );

  // tune words are not parameter-set words
  // mirrors the fetch word strobe so the port comes straight from a flop
  logic pv_q, pv_d;
  always_comb begin
    pv_d = nvm_rd_req & nvm_rd_ack & (job_q != rxpsl_pkg::RXPSL_JOB_LDO);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pv_q <= 1'b0;
    end else begin
      pv_q <= pv_d;
    end
  end

  assign wb_ack_o                = ack_q;
  assign wb_dat_o                = rdat_q;
  assign rx_param_valid          = pv_q;
  assign rx_param_data           = f_wd;
  assign rx_param_index          = f_wi;
  assign rx_param_set            = active_q;
  assign rx_param_apply          = apply_q;
  assign regulator_tune_register = tune_q;

endmodule : rxpsl_top

// *** hw/rxpsl_regs.svh ***
// register offsets, field positions, reset values and storage addresses of the loader
`ifndef RXPSL_REGS_SVH
`define RXPSL_REGS_SVH

// register indices; byte address is four times the index
`define RXPSL_IDX_SF_CTRL     6'h12
`define RXPSL_IDX_WAKE_CFG    6'h13
`define RXPSL_IDX_TUNE        6'h14
`define RXPSL_IDX_STATUS      6'h15

// special_function_control fields
`define RXPSL_SF_SET_TRIG_BIT 0
`define RXPSL_SF_CAL_TRIG_BIT 1
`define RXPSL_SF_SEL_LSB      5
`define RXPSL_SF_SEL_MSB      6
`define RXPSL_SF_RST          8'h00

// always_on_wake_config fields
`define RXPSL_WCFG_L64_BIT    0

// select codes
`define RXPSL_SEL_SHORT       2'h0
`define RXPSL_SEL_TIGHT       2'h1
`define RXPSL_SEL_DEFAULT     2'h2
`define RXPSL_SEL_RESERVED    2'h3

// storage word addresses
`define RXPSL_ADDR_TUNE_CAL   11'h004
`define RXPSL_ADDR_SET_SHORT  11'h010
`define RXPSL_ADDR_SET_TIGHT  11'h020
`define RXPSL_ADDR_SET_DFLT   11'h030

// regulator tune reset value
`define RXPSL_TUNE_RST        32'h0000_0000

`endif

// *** hw/rxpsl_pkg.sv ***
// types shared by the parameter-set loader files
package rxpsl_pkg;

  typedef enum logic [1:0] {
    RXPSL_SET_SHORT   = 2'h0,
    RXPSL_SET_TIGHT   = 2'h1,
    RXPSL_SET_DEFAULT = 2'h2,
    RXPSL_SET_NONE    = 2'h3
  } rxpsl_set_t;

  typedef enum logic [1:0] {
    RXPSL_JOB_NONE,
    RXPSL_JOB_OPS,
    RXPSL_JOB_LDO,
    RXPSL_JOB_AUTO
  } rxpsl_job_t;

  typedef enum logic [1:0] {
    RXPSL_FETCH_IDLE,
    RXPSL_FETCH_REQ,
    RXPSL_FETCH_GAP
  } rxpsl_fetch_t;

endpackage : rxpsl_pkg

// *** hw/rxpsl_fetch.sv ***
// storage word fetch engine: reads a run of consecutive words
`timescale 1ns/10ps
module rxpsl_fetch #(
  parameter int ADDR_W = 11,
  parameter int CNT_W  = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] start_addr,
  input  wire logic [CNT_W-1:0]  start_len,
  output logic                   busy,
  output logic                   done,
  output logic                   word_valid,
  output logic [31:0]            word_data,
  output logic [CNT_W-1:0]       word_index,
  output logic                   nvm_rd_req,
  output logic [ADDR_W-1:0]      nvm_rd_addr,
  input  wire logic              nvm_rd_ack,
  input  wire logic [31:0]       nvm_rd_data
);

  rxpsl_pkg::rxpsl_fetch_t state_q, state_d;
  logic [CNT_W-1:0]  left_q, left_d;
  logic [CNT_W-1:0]  idx_q, idx_d;
  logic              done_q, done_d;
  logic              wv_q, wv_d;
  logic [31:0]       wd_q, wd_d;
  logic [CNT_W-1:0]  wi_q, wi_d;
  logic              req_q, req_d;
  logic [ADDR_W-1:0] addr_q, addr_d;

  always_comb begin
    state_d = state_q;
    left_d  = left_q;
    idx_d   = idx_q;
    done_d  = 1'b0;
    wv_d    = 1'b0;
    wd_d    = wd_q;
    wi_d    = wi_q;
    req_d   = req_q;
    addr_d  = addr_q;
    unique case (state_q)
      rxpsl_pkg::RXPSL_FETCH_IDLE: begin
        if (start) begin
          addr_d  = start_addr;
          left_d  = start_len;
          idx_d   = '0;
          req_d   = 1'b1;
          state_d = rxpsl_pkg::RXPSL_FETCH_REQ;
        end
      end
      rxpsl_pkg::RXPSL_FETCH_REQ: begin
        if (nvm_rd_ack) begin
          wv_d    = 1'b1;
          wd_d    = nvm_rd_data;
          wi_d    = idx_q;
          req_d   = 1'b0;
          idx_d   = idx_q + 1'b1;
          left_d  = left_q - 1'b1;
          addr_d  = addr_q + 1'b1;
          state_d = rxpsl_pkg::RXPSL_FETCH_GAP;
        end
      end
      rxpsl_pkg::RXPSL_FETCH_GAP: begin
        // one idle cycle so a held ack never counts twice
        if (left_q == '0) begin
          done_d  = 1'b1;
          state_d = rxpsl_pkg::RXPSL_FETCH_IDLE;
        end else begin
          req_d   = 1'b1;
          state_d = rxpsl_pkg::RXPSL_FETCH_REQ;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rxpsl_pkg::RXPSL_FETCH_IDLE;
      left_q  <= '0;
      idx_q   <= '0;
      done_q  <= 1'b0;
      wv_q    <= 1'b0;
      wd_q    <= 32'h0000_0000;
      wi_q    <= '0;
      req_q   <= 1'b0;
      addr_q  <= '0;
    end else begin
      state_q <= state_d;
      left_q  <= left_d;
      idx_q   <= idx_d;
      done_q  <= done_d;
      wv_q    <= wv_d;
      wd_q    <= wd_d;
      wi_q    <= wi_d;
      req_q   <= req_d;
      addr_q  <= addr_d;
    end
  end

  assign busy        = (state_q != rxpsl_pkg::RXPSL_FETCH_IDLE);
  assign done        = done_q;
  assign word_valid  = wv_q;
  assign word_data   = wd_q;
  assign word_index  = wi_q;
  assign nvm_rd_req  = req_q;
  assign nvm_rd_addr = addr_q;

endmodule : rxpsl_fetch

// *** tb/rxpsl_top_properties.sv ***
// assertion checker for the parameter-set loader ports
`timescale 1ns/10ps
module rxpsl_chk #(
  parameter int   ADDR_W        = 11,
  parameter int   CNT_W         = 4,
  parameter int   SET_WORDS     = 4,
  parameter logic WAKE_FLAG_RST = 1'b0
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              sleep_exit,
  input wire logic              nvm_rd_req,
  input wire logic [ADDR_W-1:0] nvm_rd_addr,
  input wire logic              nvm_rd_ack,
  input wire logic [31:0]       nvm_rd_data,
  input wire logic              rx_param_valid,
  input wire logic [31:0]       rx_param_data,
  input wire logic [CNT_W-1:0]  rx_param_index,
  input wire logic [1:0]        rx_param_set,
  input wire logic              rx_param_apply
);
  logic [3:0] addr_lo;
  logic [6:0] addr_hi;
  logic       tight_req;
  assign addr_lo   = nvm_rd_addr[3:0];
  assign addr_hi   = nvm_rd_addr[10:4];
  assign tight_req = nvm_rd_req && (addr_hi == 7'h02);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_word_taken;
    nvm_rd_req && nvm_rd_ack;
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_REQ_HOLD: assert property (nvm_rd_req && !nvm_rd_ack |=> nvm_rd_req && $stable(nvm_rd_addr))
    else $error("storage request dropped or moved before ack");
  AST_REQ_GAP: assert property (s_word_taken |=> !nvm_rd_req)
    else $error("storage request not dropped after ack");
  AST_WORD_OUT: assert property (s_word_taken and addr_hi != 7'h00 |=> rx_param_valid
    && rx_param_data == $past(nvm_rd_data) && rx_param_index == CNT_W'($past(addr_lo)))
    else $error("fetched set word not delivered");
  AST_TUNE_NOWORD: assert property (s_word_taken and nvm_rd_addr == 11'h004 |=> !rx_param_valid)
    else $error("tune word delivered as set word");
  AST_ADDR_LEGAL: assert property (nvm_rd_req |-> nvm_rd_addr == 11'h004
    || (addr_hi inside {7'h01, 7'h02, 7'h03} && addr_lo < SET_WORDS))
    else $error("storage address outside known sets");
  AST_VALID_PULSE: assert property (rx_param_valid |=> !rx_param_valid)
    else $error("word valid longer than one cycle");
  AST_APPLY_PULSE: assert property (rx_param_apply |=> !rx_param_apply)
    else $error("apply longer than one cycle");
  AST_RST_DEFAULT: assert property ($rose(rst_n) && !WAKE_FLAG_RST |-> ##[0:4] rx_param_set == 2'h2)
    else $error("default set not active after reset");
  AST_NO_AUTO_TIGHT: assert property ($rose(sleep_exit) |=> !tight_req [*8])
    else $error("tight set fetched on wake");
endmodule : rxpsl_chk

bind rxpsl_top rxpsl_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W), .SET_WORDS(SET_WORDS),
  .WAKE_FLAG_RST(WAKE_FLAG_RST)) i_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleep_exit(sleep_exit),
  .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_ack(nvm_rd_ack),
  .nvm_rd_data(nvm_rd_data), .rx_param_valid(rx_param_valid),
  .rx_param_data(rx_param_data), .rx_param_index(rx_param_index),
  .rx_param_set(rx_param_set), .rx_param_apply(rx_param_apply));

// *** tb/tb_top.sv ***
// self-checking bench for the parameter-set loader
`timescale 1ns/10ps
module tb_top;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slp = 0, ack = 0;
  logic        ack_o, req, valid, apply;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, ddat = 32'h0000_0000, rdat, dat_o, pdat, tune;
  logic [10:0] raddr, base = 11'h000;
  logic [3:0]  idx, bsel = 4'hF, wsel = 4'hF;
  logic [1:0]  set, sel, dly = 2'h0;
  int          seed = 12, error_cnt = 0, samples_checked = 0, nwords = 0, cyc_cnt = 0, napply = 0;
  always #4 clk = ~clk;
  rxpsl_top #(.SET_WORDS(4)) i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack_o), .sleep_exit(slp), .nvm_rd_req(req),
    .nvm_rd_addr(raddr), .nvm_rd_ack(ack), .nvm_rd_data(ddat), .rx_param_valid(valid),
    .rx_param_data(pdat), .rx_param_index(idx), .rx_param_set(set),
    .rx_param_apply(apply), .regulator_tune_register(tune));
  function automatic logic [31:0] mem_word(input logic [10:0] a);
    return {5'h0b, a, 5'h15, a};
  endfunction : mem_word
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    bsel <= wsel;
    do @(posedge clk); while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // trigger, then poll until the trigger bits drop
  task automatic load(input logic [7:0] sf);
    wb(1'b1, 8'h48, {24'h0, sf});
    do wb(1'b0, 8'h48, 32'h0); while (rdat[1:0] !== 2'b00);
  endtask : load
  task automatic wake(input logic [1:0] s);
    int n;
    n = 0;
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    slp <= 1'b0;
    while (set !== s && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("wake_set", {30'h0, set}, {30'h0, s});
  endtask : wake
  // storage side: random answer delay, data scrambled once released
  always @(posedge clk) begin
    ack <= 1'b0;
    if (req && !ack) begin
      if (dly == 2'h0) begin
        ack <= 1'b1;
        ddat <= mem_word(raddr);
        dly <= 2'($random(seed));
      end else dly <= dly - 2'h1;
    end else ddat <= ~ddat;
  end
  always @(posedge clk) begin
    if (valid === 1'b1) begin
      chk("index", {28'h0, idx}, 32'(nwords));
      nwords++;
      chk("word", pdat, mem_word(base + {7'h0, idx}));
    end
    if (apply === 1'b1) napply++;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("set_rst", {30'h0, set}, 32'h2);
    chk("words_rst", 32'(nwords), 32'h0);
    wb(1'b1, 8'h48, 32'h0000_0020);
    wb(1'b0, 8'h48, 32'h0);
    chk("sf_rw", rdat, 32'h0000_0020);
    wb(1'b0, 8'h7C, 32'h0);
    chk("unmapped", rdat, 32'h0);
    // corners 00..11 first, then random selects
    for (int i = 0; i < 10; i++) begin
      sel = (i < 4) ? 2'(i) : 2'(unsigned'($random(seed)) % 3);
      base = {5'h0, sel, 4'h0} + 11'h010;
      nwords = 0;
      napply = 0;
      load({1'b0, sel, 5'h01});
      chk("sf_clr", rdat, {25'h0, sel, 5'h00});
      chk("apply", 32'(napply), (sel == 2'h3) ? 32'h0 : 32'h1);
      chk("nwords", 32'(nwords), (sel == 2'h3) ? 32'h0 : 32'h4);
      if (sel != 2'h3) chk("set", {30'h0, set}, {30'h0, sel});
    end
    load(8'h02);
    wb(1'b0, 8'h50, 32'h0);
    chk("tune_reg", rdat, mem_word(11'h004));
    chk("tune_port", tune, mem_word(11'h004));
    wb(1'b1, 8'h4C, 32'h1);
    wb(1'b0, 8'h4C, 32'h0);
    chk("wcfg", rdat, 32'h1);
    wsel = 4'h0;
    wb(1'b1, 8'h4C, 32'h0);
    wsel = 4'hF;
    wb(1'b0, 8'h4C, 32'h0);
    chk("wcfg_lane", rdat, 32'h1);
    base = 11'h020;
    nwords = 0;
    load(8'h21);
    chk("tight_words", 32'(nwords), 32'h4);
    chk("tight_set", {30'h0, set}, 32'h1);
    base = 11'h010;
    nwords = 0;
    wake(2'h0);
    chk("wake_words", 32'(nwords), 32'h4);
    wb(1'b1, 8'h4C, 32'h0);
    nwords = 0;
    wake(2'h2);
    chk("wake_words0", 32'(nwords), 32'h0);
    wb(1'b0, 8'h54, 32'h0);
    chk("status", rdat, 32'h2);
    summarize();
  end
endmodule : tb_top
